/* common/iso_rate_converter_pkg.sv */
package iso_rate_converter_pkg;

   // ----------------------------------------
   // geometry and register map (word indices)
   // ----------------------------------------
   localparam int NUM_CONV = 3;
   localparam int NUM_PATHS = 8;
   localparam int REG_STRIDE = 3;
   localparam logic [11:0] CONV1_HIGH_IDX = 12'hef0;
   localparam logic [11:0] CONV1_LOW_IDX = 12'hef1;
   localparam logic [11:0] CONV1_EN_IDX = 12'hef2;
   localparam logic [11:0] STATUS1_IDX = 12'hf00;
   localparam logic [15:0] REG_RESET = 16'h0000;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int RATE_MSB = 14;
   localparam int RATE_LSB = 11;
   localparam int UP_MSB = 15;
   localparam int DOWN_MSB = 9;
   localparam int NOTCH_BIT = 0;
   localparam int ERR_BIT = 1;

   // ----------------------------------------
   // rate codes and limits
   // ----------------------------------------
   localparam logic [3:0] RATE_MAIN1 = 4'h0;
   localparam logic [3:0] RATE_MAIN2 = 4'h1;
   localparam logic [3:0] RATE_MAIN3 = 4'h2;
   localparam logic [3:0] RATE_SEC1 = 4'h8;
   localparam logic [3:0] RATE_SEC2 = 4'h9;
   localparam logic [7:0] MIN_KHZ = 8'h08;
   localparam logic [7:0] MAX_KHZ = 8'hc0;
   localparam int MAX_RATIO = 24;
   localparam int LOAD_W = 13;

   typedef enum logic [1:0] {
      KIND_HIGH = 2'h0,
      KIND_LOW = 2'h1,
      KIND_EN = 2'h2,
      KIND_STAT = 2'h3
   } reg_kind_t;

   typedef struct packed {
      logic [7:0] r1;
      logic [7:0] r2;
      logic [7:0] r3;
   } main_rates_t;

   typedef struct packed {
      logic [7:0] r1;
      logic [7:0] r2;
   } sec_rates_t;

   typedef struct packed {
      logic valid;
      logic sec_dom;
      logic [7:0] khz;
   } rate_info_t;

   typedef struct packed {
      logic hit;
      logic [1:0] conv;
      reg_kind_t kind;
   } reg_dec_t;

   typedef struct packed {
      logic [3:0] hi;
      logic [3:0] lo;
      logic [7:0] req;
      logic notch;
      logic [7:0] act;
      logic err;
   } conv_state_t;

   typedef struct packed {
      logic [7:0] active;
      logic notch;
      logic [4:0] ratio;
      logic sec_dom;
      logic [7:0] hi_khz;
   } conv_report_t;

   typedef struct packed {
      conv_state_t [NUM_CONV-1:0] cs;
      conv_report_t [NUM_CONV-1:0] rep;
      logic [31:0] rdata;
      logic uc_pulse;
   } state_t;

endpackage

/* tb/core_clock_model.sv */
`timescale 1ns/1ps
`default_nettype none
module core_clock_model
   import iso_rate_converter_pkg::*;
(
   input wire logic pclk,
   input wire logic starve,
   output main_rates_t main_rates,
   output sec_rates_t sec_rates,
   output logic [LOAD_W-1:0] main_budget,
   output logic [LOAD_W-1:0] sec_budget
);
   // ----------------------------------------
   // rate generators and clock budget
   // ----------------------------------------
   // rates stay static and integer related, and each routed source runs at its path's rate
   assign main_rates = '{r1: 8'h30, r2: 8'h10, r3: 8'hc0};
   assign sec_rates = '{r1: 8'h58, r2: 8'h2c};
   assign sec_budget = 13'h0100;
   // starving leaves room for exactly two 48 kHz paths
   always_ff @(posedge pclk) main_budget <= starve ? 13'h0060 : 13'h1000;
endmodule
`default_nettype wire

/* tb/iso_rate_converter_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module rate_conv_checker
   import iso_rate_converter_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire conv_report_t [NUM_CONV-1:0] conv_report,
   input wire logic underclock_flag,
   input wire logic underclock_pulse
);
   // ----------------------------------------
   // properties on the bus, the underclock flag and pulse, and converter one
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic en_wr;
   assign en_wr = psel && penable && pwrite && paddr == 16'h3bc8;
   property p_ready; pready; endproperty
   a_ready: assert property (p_ready) else $error("pready low");
   property p_err_phase; pslverr |-> psel && penable; endproperty
   a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
   property p_upper; prdata[31:16] == 16'h0000; endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   property p_ratio; conv_report[0].active != 8'h00 |-> conv_report[0].ratio inside {[5'd1:5'd24]};
   endproperty
   a_ratio: assert property (p_ratio) else $error("ratio out of range");
   property p_range; conv_report[0].active != 8'h00 |-> conv_report[0].hi_khz >= 8'h08
      && conv_report[0].hi_khz <= 8'hc0; endproperty
   a_range: assert property (p_range) else $error("rate out of range");
   property p_up_off; en_wr && !pwdata[15] |-> ##2 !conv_report[0].active[7]; endproperty
   a_up_off: assert property (p_up_off) else $error("up path stayed on");
   property p_dn_off; en_wr && !pwdata[9] |-> ##2 !conv_report[0].active[3]; endproperty
   a_dn_off: assert property (p_dn_off) else $error("down path stayed on");
   property p_notch; en_wr |-> ##2 conv_report[0].notch == $past(pwdata[0], 2); endproperty
   a_notch: assert property (p_notch) else $error("notch not followed");
   property p_keep; $changed(conv_report[0].active) |-> $past(en_wr) || $past(en_wr, 2);
   endproperty
   a_keep: assert property (p_keep) else $error("paths changed unasked");
   property p_flag; underclock_pulse |-> underclock_flag; endproperty
   a_flag: assert property (p_flag) else $error("pulse without flag");
   property p_cause; underclock_pulse |-> $past(psel && penable && pwrite); endproperty
   a_cause: assert property (p_cause) else $error("pulse without write");
   c_en: cover property (en_wr && pwdata[15]);
   c_pulse: cover property (underclock_pulse);
   c_err: cover property (pslverr);
endmodule
bind iso_rate_converter rate_conv_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .conv_report(conv_report),
   .underclock_flag(underclock_flag), .underclock_pulse(underclock_pulse));
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import iso_rate_converter_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, starve, pready, pslverr, er;
   logic underclock_flag, underclock_pulse;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   main_rates_t main_rates;
   sec_rates_t sec_rates;
   logic [LOAD_W-1:0] main_budget, sec_budget;
   conv_report_t [NUM_CONV-1:0] conv_report;
   int bad_count, n_tests, pulses;
   typedef struct packed {logic [15:0] a; logic [31:0] d; logic [31:0] e;} row_t;
   row_t rows [5] = '{'{16'h3bcc, 32'h4000, 32'h4000}, '{16'h3bd0, 32'h4800, 32'h4800},
      '{16'h3bd8, 32'h7800, 32'h7800}, '{16'h3be0, 32'habcd0001, 32'h0001},
      '{16'h3bc4, 32'h0800, 32'h0800}};
   iso_rate_converter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .main_rates(main_rates), .sec_rates(sec_rates),
      .main_budget(main_budget), .sec_budget(sec_budget), .conv_report(conv_report),
      .underclock_flag(underclock_flag), .underclock_pulse(underclock_pulse));
   core_clock_model far (.pclk(pclk), .starve(starve), .main_rates(main_rates),
      .sec_rates(sec_rates), .main_budget(main_budget), .sec_budget(sec_budget));
   // ----------------------------------------
   // clock, checks and bus tasks
   // ----------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // sampled on the falling edge so flop updates have landed
   always @(negedge pclk) if (underclock_pulse === 1'b1) pulses++;
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge pclk);
         i++;
      end
      while (pready !== 1'b1 && i < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i >= 16)
      begin
         bad_count++;
         $display("[ERR] %0t no pready", $time);
         complete_run();
      end
   endtask
   task automatic rchk(input logic [15:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(rd, e);
   endtask
   task automatic settle();
      repeat (2) @(negedge pclk);
   endtask
   // source selectors stay at zero from reset; rate fields are written only
   // once they have been quiet for 125 us, 25000 cycles of 5 ns
   task automatic quiet_sources();
      repeat (25000) @(posedge pclk);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      {presetn, psel, penable, pwrite, starve} = 5'h00;
      paddr = 16'h0000;
      pwdata = 32'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      quiet_sources();
      foreach (rows[k])
      begin
         apb(1'b1, rows[k].a, rows[k].d);
         rchk(rows[k].a, rows[k].e);
      end
      $display("register table done");
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      quiet_sources();
      rchk(16'h3bc0, 32'h0);
      rchk(16'h3bc4, 32'h0);
      rchk(16'h3bc8, 32'h0);
      rchk(16'h3c00, 32'h0);
      apb(1'b1, 16'h3bc9, 32'hffff);
      check(er, 1'b1);
      rchk(16'h0006, 32'h0);
      check(er, 1'b1);
      $display("reset and unmapped done");
      apb(1'b1, 16'h3bc4, 32'h0800);
      apb(1'b1, 16'h3bc8, 32'hf3c1);
      settle();
      check(conv_report[0], conv_report_t'{8'hff, 1'b1, 5'd3, 1'b0, 8'h30});
      rchk(16'h3c00, 32'hf3c0);
      check(underclock_flag, 1'b0);
      $display("grant done");
      starve <= 1'b1;
      apb(1'b1, 16'h3bc8, 32'h0);
      apb(1'b1, 16'h3bc8, 32'hf000);
      settle();
      check(conv_report[0].active, 8'hc0);
      check(underclock_flag, 1'b1);
      check(pulses, 1);
      rchk(16'h3c00, 32'hc002);
      apb(1'b1, 16'h3bc8, 32'hc200);
      settle();
      check(conv_report[0].active, 8'hc0);
      check(pulses, 2);
      apb(1'b1, 16'h3c00, 32'h2);
      settle();
      check(underclock_flag, 1'b0);
      rchk(16'h3c00, 32'hc000);
      $display("refusal done");
      apb(1'b1, 16'h3bcc, 32'h4000);
      apb(1'b1, 16'h3bd0, 32'h4800);
      apb(1'b1, 16'h3bd4, 32'h0200);
      settle();
      check(conv_report[1], conv_report_t'{8'h08, 1'b0, 5'd2, 1'b1, 8'h58});
      apb(1'b1, 16'h3bd8, 32'h7800);
      apb(1'b1, 16'h3be0, 32'h8000);
      settle();
      check(conv_report[2].active, 8'h00);
      check(pulses, 3);
      $display("secondary and reserved done");
      starve <= 1'b0;
      apb(1'b1, 16'h3bd8, 32'h1000);
      apb(1'b1, 16'h3be0, 32'h8000);
      settle();
      check(conv_report[2], conv_report_t'{8'h80, 1'b0, 5'd4, 1'b0, 8'hc0});
      check(pulses, 3);
      check(underclock_flag, 1'b1);
      $display("top rate done");
      complete_run();
   end
endmodule
`default_nettype wire

/* verilog/iso_rate_converter.sv */
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module iso_rate_converter
   import iso_rate_converter_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire main_rates_t main_rates,
   input wire sec_rates_t sec_rates,
   input wire logic [LOAD_W-1:0] main_budget,
   input wire logic [LOAD_W-1:0] sec_budget,
   output conv_report_t [NUM_CONV-1:0] conv_report,
   output logic underclock_flag,
   output logic underclock_pulse
);

   // ----------------------------------------
   // helper functions
   // ----------------------------------------
   function automatic rate_info_t rate_lookup(
      input logic [3:0] code,
      input main_rates_t m,
      input sec_rates_t s
   );
      rate_info_t r;
      r = '0;
      case (code)
         RATE_MAIN1:
         begin
            r.valid = 1'b1;
            r.khz = m.r1;
         end
         RATE_MAIN2:
         begin
            r.valid = 1'b1;
            r.khz = m.r2;
         end
         RATE_MAIN3:
         begin
            r.valid = 1'b1;
            r.khz = m.r3;
         end
         RATE_SEC1:
         begin
            r.valid = 1'b1;
            r.sec_dom = 1'b1;
            r.khz = s.r1;
         end
         RATE_SEC2:
         begin
            r.valid = 1'b1;
            r.sec_dom = 1'b1;
            r.khz = s.r2;
         end
         default:
         begin
            r = '0;
         end
      endcase
      return r;
   endfunction

   // zero means the pair cannot run: reserved code, mixed domains,
   // out of range, or not an integer ratio
   function automatic logic [4:0] ratio_of(
      input rate_info_t hi,
      input rate_info_t lo
   );
      logic [4:0] k;
      logic ok;
      k = '0;
      ok = hi.valid && lo.valid;
      ok = ok && (hi.sec_dom == lo.sec_dom);
      ok = ok && (lo.khz >= MIN_KHZ) && (hi.khz <= MAX_KHZ);
      if (ok)
      begin
         for (int i = 1; i <= MAX_RATIO; i++)
         begin
            if (LOAD_W'(lo.khz) * LOAD_W'(i) == LOAD_W'(hi.khz))
            begin
               k = 5'(i);
            end
         end
      end
      return k;
   endfunction

   // every path is costed at its converter's high rate in kHz, so one
   // budget unit means the same on both domains
   function automatic logic [LOAD_W-1:0] cost_of(input rate_info_t hi);
      return LOAD_W'(hi.khz);
   endfunction

   function automatic logic [7:0] paths_of(input logic [15:0] w);
      return {w[UP_MSB -: 4], w[DOWN_MSB -: 4]};
   endfunction

   function automatic logic [15:0] field_of(input logic [7:0] p);
      logic [15:0] w;
      w = REG_RESET;
      w[UP_MSB -: 4] = p[7:4];
      w[DOWN_MSB -: 4] = p[3:0];
      return w;
   endfunction

   function automatic reg_dec_t decode(input logic [15:0] a);
      reg_dec_t d;
      logic [11:0] idx;
      d = '0;
      idx = a[13:2];
      for (int c = 0; c < NUM_CONV; c++)
      begin
         if (idx == CONV1_HIGH_IDX + 12'(REG_STRIDE * c))
         begin
            d = '{1'b1, 2'(c), KIND_HIGH};
         end
         if (idx == CONV1_LOW_IDX + 12'(REG_STRIDE * c))
         begin
            d = '{1'b1, 2'(c), KIND_LOW};
         end
         if (idx == CONV1_EN_IDX + 12'(REG_STRIDE * c))
         begin
            d = '{1'b1, 2'(c), KIND_EN};
         end
         if (idx == STATUS1_IDX + 12'(c))
         begin
            d = '{1'b1, 2'(c), KIND_STAT};
         end
      end
      if (a[15:14] != 2'b00 || a[1:0] != 2'b00)
      begin
         d.hit = 1'b0;
      end
      return d;
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   state_t state_ff;
   state_t nxt_state;
   rate_info_t [NUM_CONV-1:0] hi_info;
   rate_info_t [NUM_CONV-1:0] lo_info;
   logic [NUM_CONV-1:0][4:0] ratio;
   logic [LOAD_W-1:0] load_main;
   logic [LOAD_W-1:0] load_sec;
   logic [LOAD_W-1:0] load_sel;
   logic [LOAD_W-1:0] budget_sel;
   reg_dec_t dec;
   logic [1:0] wc;
   logic wr_en;
   logic refused;
   logic [7:0] req;
   logic [7:0] rise;
   logic [15:0] rd_word;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      nxt_state = state_ff;
      nxt_state.uc_pulse = 1'b0;
      refused = 1'b0;
      req = '0;
      rise = '0;
      rd_word = REG_RESET;
      load_main = '0;
      load_sec = '0;
      load_sel = '0;
      budget_sel = '0;

      // rate decode for every converter, independently of the others
      for (int c = 0; c < NUM_CONV; c++)
      begin
         hi_info[c] = rate_lookup(state_ff.cs[c].hi, main_rates, sec_rates);
         lo_info[c] = rate_lookup(state_ff.cs[c].lo, main_rates, sec_rates);
         ratio[c] = ratio_of(hi_info[c], lo_info[c]);
      end

      // clock load already committed on each domain; every path
      // is costed at its converter's high rate
      for (int c = 0; c < NUM_CONV; c++)
      begin
         for (int b = 0; b < NUM_PATHS; b++)
         begin
            if (state_ff.cs[c].act[b])
            begin
               if (hi_info[c].sec_dom)
               begin
                  load_sec = load_sec + cost_of(hi_info[c]);
               end
               else
               begin
                  load_main = load_main + cost_of(hi_info[c]);
               end
            end
         end
      end

      dec = decode(paddr);
      wc = dec.conv;
      wr_en = psel && penable && pwrite && dec.hit;

      // read data is captured in the setup cycle so the access
      // phase can finish with no wait state
      if (dec.hit)
      begin
         unique case (dec.kind)
            KIND_HIGH:
            begin
               rd_word[RATE_MSB:RATE_LSB] = state_ff.cs[wc].hi;
            end
            KIND_LOW:
            begin
               rd_word[RATE_MSB:RATE_LSB] = state_ff.cs[wc].lo;
            end
            KIND_EN:
            begin
               rd_word = field_of(state_ff.cs[wc].req);
               rd_word[NOTCH_BIT] = state_ff.cs[wc].notch;
            end
            KIND_STAT:
            begin
               rd_word = field_of(state_ff.cs[wc].act);
               rd_word[ERR_BIT] = state_ff.cs[wc].err;
            end
         endcase
      end
      if (psel && !penable)
      begin
         nxt_state.rdata = {16'h0000, rd_word};
      end

      // rate fields are taken even while paths run; idling the paths and
      // their sources first is left to software
      if (wr_en)
      begin
         unique case (dec.kind)
            KIND_HIGH:
            begin
               nxt_state.cs[wc].hi = pwdata[RATE_MSB:RATE_LSB];
            end
            KIND_LOW:
            begin
               nxt_state.cs[wc].lo = pwdata[RATE_MSB:RATE_LSB];
            end
            KIND_EN:
            begin
               req = paths_of(pwdata[15:0]);
               nxt_state.cs[wc].req = req;
               nxt_state.cs[wc].notch = pwdata[NOTCH_BIT];
               // clearing a bit stops its path at once
               nxt_state.cs[wc].act = state_ff.cs[wc].act & req;
               rise = req & ~state_ff.cs[wc].act;
               load_sel = hi_info[wc].sec_dom ? load_sec : load_main;
               budget_sel = hi_info[wc].sec_dom ? sec_budget : main_budget;
               // new paths are granted from up path one downward while the
               // budget lasts; running paths are never revoked
               for (int b = NUM_PATHS - 1; b >= 0; b--)
               begin
                  if (rise[b])
                  begin
                     if (ratio[wc] != 5'h00 &&
                         load_sel + cost_of(hi_info[wc]) <= budget_sel)
                     begin
                        nxt_state.cs[wc].act[b] = 1'b1;
                        load_sel = load_sel + cost_of(hi_info[wc]);
                     end
                     else
                     begin
                        refused = 1'b1;
                     end
                  end
               end
            end
            KIND_STAT:
            begin
               if (pwdata[ERR_BIT])
               begin
                  nxt_state.cs[wc].err = 1'b0;
               end
            end
         endcase
      end

      // a refusal in the same cycle as a clear leaves the flag set
      if (refused)
      begin
         nxt_state.cs[wc].err = 1'b1;
         nxt_state.uc_pulse = 1'b1;
      end

      // settings handed to each converter's filter and paths
      for (int c = 0; c < NUM_CONV; c++)
      begin
         nxt_state.rep[c].active = nxt_state.cs[c].act;
         nxt_state.rep[c].notch = nxt_state.cs[c].notch;
         nxt_state.rep[c].ratio = ratio[c];
         nxt_state.rep[c].sec_dom = hi_info[c].sec_dom;
         nxt_state.rep[c].hi_khz = hi_info[c].khz;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign prdata = state_ff.rdata;
   assign pready = 1'b1;
   // unmapped words answer with an error but still finish at once
   assign pslverr = psel && penable && !dec.hit;
   assign conv_report = state_ff.rep;
   assign underclock_pulse = state_ff.uc_pulse;
   assign underclock_flag = state_ff.cs[0].err || state_ff.cs[1].err ||
                            state_ff.cs[2].err;

endmodule
`default_nettype wire
